// >>> verilog/rf_level_pkg.sv
// Purpose: Shared constants for the antenna driver level register group
// Assumes: 8-bit register port, one clock
// Notes:   Offsets are byte addresses on the register port
package rf_level_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int SEG_N  = 8;
    localparam int MV_W   = 10;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_DEPTH_CTRL    = 8'h24;
    localparam logic [7:0] ADDR_CAL_RESULT    = 8'h25;
    localparam logic [7:0] ADDR_MOD_MASK      = 8'h26;
    localparam logic [7:0] ADDR_UNMOD_MASK    = 8'h27;
    localparam logic [7:0] ADDR_FIELD_THRESH  = 8'h29;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int SRC_SEL_BIT   = 7;
    localparam int DEPTH_MSB     = 6;
    localparam int DEPTH_LSB     = 1;
    localparam int PEER_MSB      = 6;
    localparam int PEER_LSB      = 4;
    localparam int COLL_MSB      = 3;
    localparam int COLL_LSB      = 0;
    localparam int COLL_RANGE_BIT = 3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values, fixed patterns and the threshold write mask
    localparam logic [7:0] RST_DEPTH_CTRL   = 8'h00;
    localparam logic [7:0] RST_CAL_RESULT   = 8'h00;
    localparam logic [7:0] RST_SEG_MASK     = 8'h00;
    localparam logic [7:0] RST_FIELD_THRESH = 8'h33;
    localparam logic [7:0] CAL_FAIL_VALUE   = 8'hFF;
    localparam logic [7:0] ALL_SEG_OFF      = 8'hFF;
    localparam logic [7:0] READ_ZERO        = 8'h00;
    localparam logic [7:0] THRESH_WR_MASK   = 8'h7F;

    // Driver phase seen by the segment logic
    typedef enum logic [0:0] {
        PHASE_NORMAL = 1'b0,
        PHASE_AM     = 1'b1
    } drv_phase_t;

endpackage

// >>> verilog/field_threshold_decode.sv
// Purpose: Turns the detector threshold codes into nominal mV levels
// Assumes: Codes come straight from the threshold register
// Notes:   Outputs are registered, one cycle behind the codes
`timescale 1ns/1ns
`default_nettype none
module field_threshold_decode
    import rf_level_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            arst_n,
    input  wire logic [2:0]      peer_code,
    input  wire logic [3:0]      coll_code,
    output logic      [MV_W-1:0] peer_mv_r,
    output logic      [MV_W-1:0] coll_mv_r,
    output logic                 coll_low_range_r
);

    // Shared ladder for the normal range of both detectors
    function automatic logic [MV_W-1:0] ladder_mv(input logic [2:0] c);
        case (c)
            3'h0:    ladder_mv = 10'd75;
            3'h1:    ladder_mv = 10'd105;
            3'h2:    ladder_mv = 10'd150;
            3'h3:    ladder_mv = 10'd205;
            3'h4:    ladder_mv = 10'd290;
            3'h5:    ladder_mv = 10'd400;
            3'h6:    ladder_mv = 10'd560;
            default: ladder_mv = 10'd800;
        endcase
    endfunction

    // Low range for collision avoidance, top code bit set
    function automatic logic [MV_W-1:0] low_mv(input logic [2:0] c);
        case (c)
            3'h0:    low_mv = 10'd25;
            3'h1:    low_mv = 10'd33;
            3'h2:    low_mv = 10'd47;
            3'h3:    low_mv = 10'd64;
            3'h4:    low_mv = 10'd90;
            3'h5:    low_mv = 10'd125;
            3'h6:    low_mv = 10'd175;
            default: low_mv = 10'd250;
        endcase
    endfunction

    // Registered decode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            peer_mv_r        <= '0;
            coll_mv_r        <= '0;
            coll_low_range_r <= 1'b0;
        end else begin
            peer_mv_r        <= ladder_mv(peer_code);
            coll_low_range_r <= coll_code[3];
            coll_mv_r        <= coll_code[3] ? low_mv(coll_code[2:0])
                                             : ladder_mv(coll_code[2:0]);
        end
    end

endmodule
`default_nettype wire

// >>> verilog/driver_segment_select.sv
// Purpose: Picks the segment disable pattern for the current driver phase
// Assumes: Phase input is synchronous to clk
// Notes:   Pattern and tristate flag are registered
`timescale 1ns/1ns
`default_nettype none
module driver_segment_select
    import rf_level_pkg::*;
#(
    parameter int SEGS = SEG_N
) (
    input  wire logic            clk,
    input  wire logic            arst_n,
    input  wire logic            am_phase,
    input  wire logic            use_sw_mask,
    input  wire logic [SEGS-1:0] cal_pattern,
    input  wire logic [SEGS-1:0] am_mask,
    input  wire logic [SEGS-1:0] normal_mask,
    output logic      [SEGS-1:0] seg_off_r,
    output logic                 drv_hiz_r
);

    logic [SEGS-1:0] am_pick;
    logic [SEGS-1:0] seg_nxt;

    // AM pattern source: calibration result or software mask
    assign am_pick = use_sw_mask ? am_mask : cal_pattern;
    assign seg_nxt = (am_phase == PHASE_AM) ? am_pick : normal_mask;

    // Bit 7 is the 2 Ohm segment, bit 0 the 256 Ohm one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seg_off_r <= '0;
            drv_hiz_r <= 1'b0;
        end else begin
            seg_off_r <= seg_nxt;
            drv_hiz_r <= (am_phase == PHASE_NORMAL) && (&normal_mask);
        end
    end

endmodule
`default_nettype wire

// >>> verilog/rf_driver_level_regs.sv
// Purpose: Antenna driver level and field detector threshold registers
// Assumes: Single clk at 25 MHz, host register port synchronous to it
// Notes:   Read data appear one cycle after the read strobe
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rf_driver_level_regs
    import rf_level_pkg::*;
#(
    parameter int SEGS = SEG_N
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Host register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata_r,
    // Restore-defaults command, one-cycle pulse
    input  wire logic              restore_defaults,
    // Calibration engine result
    input  wire logic              cal_done,
    input  wire logic              cal_fail,
    input  wire logic [SEGS-1:0]   cal_seg_bit,
    // Transmitter phase: high while AM modulated
    input  wire logic              am_phase,
    // Driver and detector controls
    output logic      [SEGS-1:0]   seg_off_r,
    output logic                   drv_hiz_r,
    output logic      [5:0]        mod_depth_r,
    output logic      [MV_W-1:0]   peer_mv_r,
    output logic      [MV_W-1:0]   coll_mv_r,
    output logic                   coll_low_range_r,
    output logic      [2:0]        peer_threshold_code_r,
    output logic      [3:0]        collision_threshold_code_r
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // One place decides whether a write hits a given register; reads decode in the read mux
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        target);
        hit = (a == target);
    endfunction

    logic wr_ctrl;
    logic wr_mod;
    logic wr_unmod;
    logic wr_thresh;

    // Write enables; no enable exists for 25h
    assign wr_ctrl   = reg_wr && hit(reg_addr, ADDR_DEPTH_CTRL);
    assign wr_mod    = reg_wr && hit(reg_addr, ADDR_MOD_MASK);
    assign wr_unmod  = reg_wr && hit(reg_addr, ADDR_UNMOD_MASK);
    assign wr_thresh = reg_wr && hit(reg_addr, ADDR_FIELD_THRESH);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [DATA_W-1:0] depth_ctrl_r;
    logic [SEGS-1:0]   depth_cal_result_r;
    logic [SEGS-1:0]   modulated_segment_mask_r;
    logic [SEGS-1:0]   unmodulated_segment_mask_r;
    logic [DATA_W-1:0] field_detect_thresholds_r;
    logic [SEGS-1:0]   cal_result_nxt;

    logic              am_level_source_sel;
    logic [2:0]        peer_code;
    logic [3:0]        coll_code;

    // Field views
    assign am_level_source_sel = depth_ctrl_r[SRC_SEL_BIT];
    assign peer_code = field_detect_thresholds_r[PEER_MSB:PEER_LSB];
    assign coll_code = field_detect_thresholds_r[COLL_MSB:COLL_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Modulation depth control at 24h

    // Restore defaults beats a write in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            depth_ctrl_r <= RST_DEPTH_CTRL;
        end else if (restore_defaults) begin
            depth_ctrl_r <= RST_DEPTH_CTRL;
        end else if (wr_ctrl) begin
            depth_ctrl_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration result at 25h

    // Failed run reports every segment disabled
    always_comb begin
        cal_result_nxt = depth_cal_result_r;
        if (cal_done) begin
            if (cal_fail) begin
                cal_result_nxt = CAL_FAIL_VALUE;
            end else begin
                cal_result_nxt = cal_seg_bit;
            end
        end
    end

    // Loaded by the calibration engine and cleared by restore; host writes have no path
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            depth_cal_result_r <= RST_CAL_RESULT;
        end else if (restore_defaults) begin
            depth_cal_result_r <= RST_CAL_RESULT;
        end else begin
            depth_cal_result_r <= cal_result_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment masks at 26h and 27h

    // Modulated-state mask
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modulated_segment_mask_r <= RST_SEG_MASK;
        end else if (restore_defaults) begin
            modulated_segment_mask_r <= RST_SEG_MASK;
        end else if (wr_mod) begin
            modulated_segment_mask_r <= reg_wdata;
        end
    end

    // Unmodulated-state mask; all ones means drivers float
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            unmodulated_segment_mask_r <= RST_SEG_MASK;
        end else if (restore_defaults) begin
            unmodulated_segment_mask_r <= RST_SEG_MASK;
        end else if (wr_unmod) begin
            unmodulated_segment_mask_r <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field detector thresholds at 29h

    // Unused bit 7 is forced low so it always reads back zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            field_detect_thresholds_r <= RST_FIELD_THRESH;
        end else if (restore_defaults) begin
            field_detect_thresholds_r <= RST_FIELD_THRESH;
        end else if (wr_thresh) begin
            field_detect_thresholds_r <= reg_wdata & THRESH_WR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [DATA_W-1:0] rd_mux;

    // Unmapped addresses read as zero
    always_comb begin
        case (reg_addr)
            ADDR_DEPTH_CTRL:   rd_mux = depth_ctrl_r;
            ADDR_CAL_RESULT:   rd_mux = depth_cal_result_r;
            ADDR_MOD_MASK:     rd_mux = modulated_segment_mask_r;
            ADDR_UNMOD_MASK:   rd_mux = unmodulated_segment_mask_r;
            ADDR_FIELD_THRESH: rd_mux = field_detect_thresholds_r;
            default:           rd_mux = READ_ZERO;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end else begin
            reg_rdata_r <= READ_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field and depth outputs

    // Raw codes for the analog detector and modulator trims
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mod_depth_r                <= '0;
            peer_threshold_code_r      <= '0;
            collision_threshold_code_r <= '0;
        end else begin
            mod_depth_r                <= depth_ctrl_r[DEPTH_MSB:DEPTH_LSB];
            peer_threshold_code_r      <= peer_code;
            collision_threshold_code_r <= coll_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment selection

    // Phase change reaches the drivers one cycle later
    driver_segment_select #(
        .SEGS        (SEGS)
    ) u_seg (
        .clk         (clk),
        .arst_n      (arst_n),
        .am_phase    (am_phase),
        .use_sw_mask (am_level_source_sel),
        .cal_pattern (depth_cal_result_r),
        .am_mask     (modulated_segment_mask_r),
        .normal_mask (unmodulated_segment_mask_r),
        .seg_off_r   (seg_off_r),
        .drv_hiz_r   (drv_hiz_r)
    );

    ////////////////////////////////////////////////////////////////////////
    // Threshold decode

    // Code 0111 gives the top level recommended for active links
    field_threshold_decode u_thr (
        .clk              (clk),
        .arst_n           (arst_n),
        .peer_code        (peer_code),
        .coll_code        (coll_code),
        .peer_mv_r        (peer_mv_r),
        .coll_mv_r        (coll_mv_r),
        .coll_low_range_r (coll_low_range_r)
    );

endmodule
`default_nettype wire

// >>> tb/rf_level_sva.sv
// Purpose: Port checks for the driver level registers
// Assumes: One clock, bound to the top module
// Notes:   Register change shows on outputs two edges after the strobe
`timescale 1ns/1ns
`default_nettype none
module rf_level_sva
    import rf_level_pkg::*;
#(
    parameter int SEGS = SEG_N
) (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata_r,
    input wire logic              restore_defaults,
    input wire logic              cal_done,
    input wire logic              cal_fail,
    input wire logic              am_phase,
    input wire logic [SEGS-1:0]   seg_off_r,
    input wire logic              drv_hiz_r,
    input wire logic [MV_W-1:0]   coll_mv_r,
    input wire logic              coll_low_range_r,
    input wire logic [2:0]        peer_threshold_code_r,
    input wire logic [3:0]        collision_threshold_code_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Strobes that a restore does not overrule
    sequence wr_s(a);
        reg_wr && reg_addr == a && !restore_defaults;
    endsequence
    sequence rd_s(a);
        reg_rd && reg_addr == a && !restore_defaults && !cal_done;
    endsequence
    sequence quiet_s;
        !reg_wr && !restore_defaults;
    endsequence
    ////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata_r == 8'h00)
        else $error("read data not zero outside read slot");
    a_cal_ro: assert property (
        cal_done && cal_fail && !restore_defaults ##1
        (!cal_done && !restore_defaults) ##1
        (wr_s(ADDR_CAL_RESULT) and !cal_done)
        ##1 rd_s(ADDR_CAL_RESULT) |=> reg_rdata_r == CAL_FAIL_VALUE)
        else $error("failed calibration result lost");
    a_mask_back: assert property (
        wr_s(ADDR_UNMOD_MASK) ##1 rd_s(ADDR_UNMOD_MASK)
        |=> reg_rdata_r == $past(reg_wdata, 2))
        else $error("mask readback wrong");
    a_thresh_back: assert property (
        wr_s(ADDR_FIELD_THRESH) ##1 rd_s(ADDR_FIELD_THRESH)
        |=> reg_rdata_r == ($past(reg_wdata, 2) & THRESH_WR_MASK))
        else $error("threshold readback wrong");
    a_code_fields: assert property (
        wr_s(ADDR_FIELD_THRESH) ##1 quiet_s |=>
        peer_threshold_code_r == $past(reg_wdata[6:4], 2) &&
        collision_threshold_code_r == $past(reg_wdata[3:0], 2))
        else $error("threshold code fields wrong");
    a_hiz_write: assert property (
        (reg_wr && reg_addr == ADDR_UNMOD_MASK && !restore_defaults &&
         reg_wdata == ALL_SEG_OFF) ##1 (quiet_s and !am_phase)
        |=> drv_hiz_r && seg_off_r == ALL_SEG_OFF)
        else $error("drivers not tristated");
    a_hiz_normal: assert property (
        drv_hiz_r |-> !$past(am_phase))
        else $error("tristate while modulated");
    a_restore_seg: assert property (
        restore_defaults ##1 !reg_wr |=> seg_off_r == '0 && !drv_hiz_r)
        else $error("segments not enabled after restore");
    a_range_mv: assert property (
        $past(arst_n) |-> (coll_low_range_r ? coll_mv_r <= 10'h0fa
                                            : coll_mv_r >= 10'h04b))
        else $error("collision level outside its range");
endmodule
bind rf_driver_level_regs rf_level_sva #(.SEGS(SEGS)) chk_u (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .restore_defaults(restore_defaults),
    .cal_done(cal_done), .cal_fail(cal_fail), .am_phase(am_phase),
    .seg_off_r(seg_off_r), .drv_hiz_r(drv_hiz_r), .coll_mv_r(coll_mv_r),
    .coll_low_range_r(coll_low_range_r),
    .peer_threshold_code_r(peer_threshold_code_r),
    .collision_threshold_code_r(collision_threshold_code_r));
`default_nettype wire

// >>> tb/host_bus_model.sv
// Purpose: Host side of the register port
// Assumes: Strobes one cycle, changed right after a rising edge
// Notes:   Idle address and data show inverted values, not stale ones
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
    import rf_level_pkg::*;
(
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic      [DATA_W-1:0] reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // Write, optionally followed at once by a read of the same place
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input bit rd_next = 1'b0);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= rd_next;
        reg_wdata <= ~d;
        if (rd_next) begin
            @(posedge clk);
            reg_rd <= 1'b0;
        end
        reg_addr <= ~a;
    endtask
    // Plain read; data are taken by the bench one cycle later
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule
`default_nettype wire

// >>> tb/rf_driver_level_regs_tb.sv
// Purpose: Self-checking bench for the driver level registers
// Assumes: Host model drives the register port
// Notes:   Read results are checked from a queue of expectations
`timescale 1ns/1ns
`default_nettype none
module rf_driver_level_regs_tb
    import rf_level_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n, restore_defaults, cal_done, cal_fail, am_phase;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, cal_seg_bit, seg_off_r;
    logic reg_wr, reg_rd, drv_hiz_r, coll_low_range_r;
    logic [9:0] peer_mv_r, coll_mv_r;
    logic [2:0] peer_threshold_code_r;
    logic [5:0] mod_depth_r;
    logic [3:0] collision_threshold_code_r;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [7:0] d, pat;
    int err_count = 0;
    int checked = 0;
    int peer_tab[8] = '{75, 105, 150, 205, 290, 400, 560, 800};
    int coll_tab[16] = '{75, 105, 150, 205, 290, 400, 560, 800,
                         25, 33, 47, 64, 90, 125, 175, 250};
    always #20 clk = ~clk;
    host_bus_model hostm (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    rf_driver_level_regs dut_u (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .restore_defaults(restore_defaults), .cal_done(cal_done),
        .cal_fail(cal_fail), .cal_seg_bit(cal_seg_bit),
        .am_phase(am_phase), .seg_off_r(seg_off_r), .drv_hiz_r(drv_hiz_r),
        .mod_depth_r(mod_depth_r), .peer_mv_r(peer_mv_r),
        .coll_mv_r(coll_mv_r),
        .coll_low_range_r(coll_low_range_r),
        .peer_threshold_code_r(peer_threshold_code_r),
        .collision_threshold_code_r(collision_threshold_code_r));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t: saw %h, wanted %h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        hostm.rd(a);
    endtask
    // Outputs move two edges after a write; wait past that
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    task automatic cal(input logic f, input logic [7:0] p);
        @(posedge clk);
        cal_done <= 1'b1;
        cal_fail <= f;
        cal_seg_bit <= p;
        @(posedge clk);
        cal_done <= 1'b0;
        cal_seg_bit <= ~p;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen) begin
            check(16'(reg_rdata_r), 16'(exp_q.pop_front()));
        end
        rd_seen <= reg_rd;
    end
    // Watchdog, well beyond the few hundred cycles of the run
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {arst_n, restore_defaults, cal_done, cal_fail, am_phase} = 5'h00;
        cal_seg_bit = 8'h00;
        void'($urandom(40));
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_CAL_RESULT, 8'h00);
        rd(ADDR_MOD_MASK, 8'h00);
        rd(ADDR_UNMOD_MASK, 8'h00);
        rd(ADDR_FIELD_THRESH, 8'h33);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom());
            hostm.wr(ADDR_UNMOD_MASK, d, 1'b1);
            exp_q.push_back(d);
            hostm.wr(ADDR_FIELD_THRESH, d, 1'b1);
            exp_q.push_back(d & THRESH_WR_MASK);
            hostm.wr(8'h28, d);
            rd(8'h28, 8'h00);
        end
        // Each collision code once, peer code equal to its low three bits; bit 7 is set for codes 8 to 15
        for (int i = 0; i < 16; i++) begin
            hostm.wr(ADDR_FIELD_THRESH, 8'(i * 17));
            settle();
            check(16'(peer_mv_r), 16'(peer_tab[i % 8]));
            check(16'(coll_mv_r), 16'(coll_tab[i]));
            check(16'(coll_low_range_r), 16'(i / 8));
        end
        pat = 8'($urandom());
        cal(1'b0, pat);
        am_phase <= 1'b1;
        rd(ADDR_CAL_RESULT, pat);
        settle();
        check(16'(seg_off_r), 16'(pat));
        d = 8'($urandom());
        hostm.wr(ADDR_MOD_MASK, d);
        hostm.wr(ADDR_DEPTH_CTRL, 8'hab);
        settle();
        check(16'(seg_off_r), 16'(d));
        check(16'(mod_depth_r), 16'h0015);
        am_phase <= 1'b0;
        hostm.wr(ADDR_UNMOD_MASK, 8'hc0);
        settle();
        check(16'({drv_hiz_r, seg_off_r}), 16'h00c0);
        hostm.wr(ADDR_UNMOD_MASK, ALL_SEG_OFF);
        settle();
        check(16'({drv_hiz_r, seg_off_r}), 16'h01ff);
        am_phase <= 1'b1;
        settle();
        check(16'({drv_hiz_r, seg_off_r}), 16'(d));
        cal(1'b1, pat);
        hostm.wr(ADDR_CAL_RESULT, 8'h00, 1'b1);
        exp_q.push_back(CAL_FAIL_VALUE);
        hostm.wr(ADDR_DEPTH_CTRL, 8'h00);
        settle();
        check(16'(seg_off_r), 16'h00ff);
        // Restore in the same cycle as a write; the write must lose
        fork
            hostm.wr(ADDR_MOD_MASK, 8'ha5);
            begin
                @(posedge clk);
                restore_defaults <= 1'b1;
                @(posedge clk);
                restore_defaults <= 1'b0;
            end
        join
        rd(ADDR_MOD_MASK, 8'h00);
        rd(ADDR_UNMOD_MASK, 8'h00);
        rd(ADDR_CAL_RESULT, 8'h00);
        rd(ADDR_FIELD_THRESH, 8'h33);
        settle();
        check(16'({drv_hiz_r, seg_off_r}), 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
